// ===== inc/alarm_maint_cfg.svh
// constants for the alarm routing and maintenance block
`ifndef ALARM_MAINT_CFG_SVH
`define ALARM_MAINT_CFG_SVH
`define FULL_SEL_W 3
`define RED_SEL_W 2
`define NUM_FULL_SRC 7
`define SRC_REF 0
`define SRC_IPCTL 1
`define SRC_OVEN 2
`define SRC_MONITOR 3
`define SRC_SUPPLY 4
`define SRC_TRIAL7 5
`define SRC_TRIAL24 6
`define SEL_BIT_A 0
`define SEL_BIT_B 1
`define SEL_BIT_MUTE 2
`define VOLT_W 9
`define VOLT_MIN_DV 9'h04c
`define VOLT_MAX_DV 9'h154
`define VOLT_RST_DV 9'h050
`define HOURS_W 16
`define TRIAL7_HOURS 16'h00a8
`define TRIAL24_HOURS 16'h0018
`define TRIAL_RST_HOURS 16'h02d0
`define FEAT_CHARS 20
`define CHAR_W 8
`define CLK_PERIOD_NS 100
`define SEC_NS 1000000000
`define SEC_CYCLES (`SEC_NS / `CLK_PERIOD_NS)
`define HOUR_SECS 3600
`define DLY_W 32
`define BOOT_S1 6'h01
`define BOOT_S2 6'h02
`define BOOT_S5 6'h05
`define BOOT_S10 6'h0a
`define BOOT_S20 6'h14
`define BOOT_S50 6'h32
`endif

// ===== inc/alarm_maint_pkg.sv
// types for the alarm routing and maintenance block
`default_nettype none
`include "alarm_maint_cfg.svh"
package alarm_maint_pkg;
   typedef logic [`FULL_SEL_W-1:0] full_sel_t;
   typedef logic [`RED_SEL_W-1:0] red_sel_t;
   typedef struct packed
   {
      full_sel_t [`NUM_FULL_SRC-1:0] full;
      red_sel_t test_sel;
      red_sel_t hw_sel;
      red_sel_t beep_sel;
   } route_cfg_s;
   typedef enum logic [1:0]
   {
      TEST_OFF = 2'b00,
      TEST_LAMP = 2'b01,
      TEST_SELF = 2'b10,
      TEST_BOTH = 2'b11
   } test_mode_e;
   typedef enum logic [2:0]
   {
      BOOT_NORMAL = 3'b000,
      BOOT_NOW = 3'b001,
      BOOT_1S = 3'b010,
      BOOT_2S = 3'b011,
      BOOT_5S = 3'b100,
      BOOT_10S = 3'b101,
      BOOT_20S = 3'b110,
      BOOT_50S = 3'b111
   } boot_code_e;
   typedef enum logic [1:0]
   {
      INST_IDLE = 2'b00,
      INST_DOWNLOAD = 2'b01,
      INST_VERIFY = 2'b10,
      INST_INSTALL = 2'b11
   } install_e;
   typedef enum logic [1:0]
   {
      BST_IDLE = 2'b00,
      BST_WAIT = 2'b01,
      BST_FIRE = 2'b10
   } boot_state_e;
   typedef struct packed
   {
      logic ref_osc;
      logic ipctl;
      logic oven;
      logic monitor;
      logic hw;
   } fault_s;
endpackage
`default_nettype wire

// ===== rtl/alarm_maint.sv
// alarm routing, carrier mute, beeper and maintenance controls
// Notes on behaviour
// - full selector 0-3: none, A, B, both
// - full selector 4-7: mute plus none/A/B/both
// - reference oscillator fault has own selector
// - ip control port fault has own selector
// - monitor input fault has own selector
// - undervoltage when supply below threshold
// - threshold accepted 7.6 to 34.0 V, 0.1 V
// - trial under seven days raises warning
// - trial under 24 hours raises warning
// - beeper on never, A, B or either
// - test and hardware faults: A/B only
// - test mode off, lamp, self, both
// - boot codes: normal, now, delayed reboot
// - boot control written only in admin
// - admin selector gates boot control and image selection
// - image selection only in admin mode
// - installer status reports four states
// - accept permanent or trial feature code
// - keep remaining trial hours
// - report measured supply voltage
`include "alarm_maint_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module alarm_maint
#(
   parameter int SEC_CYCLES = `SEC_CYCLES,
   parameter int HOUR_SECS = `HOUR_SECS,
   parameter logic [`HOURS_W-1:0] TRIAL_HOURS = `TRIAL_RST_HOURS
)
(
   input wire logic MCLK_IN,
   input wire logic ARST_N_IN,
   input wire alarm_maint_pkg::route_cfg_s ROUTE_CFG_IN,
   input wire alarm_maint_pkg::fault_s FAULT_IN,
   input wire logic [`VOLT_W-1:0] SUPPLY_DV_IN,
   input wire logic THRESH_WR_IN,
   input wire logic [`VOLT_W-1:0] THRESH_DV_IN,
   input wire logic [1:0] TEST_MODE_IN,
   input wire logic ADMIN_IN,
   input wire logic BOOT_WR_IN,
   input wire logic [2:0] BOOT_CODE_IN,
   input wire logic IMAGE_WR_IN,
   input wire logic IMAGE_SEL_IN,
   input wire logic RUNNING_IMAGE_IN,
   input wire logic [1:0] INSTALL_STATE_IN,
   input wire logic FEAT_WR_IN,
   input wire logic FEAT_TRIAL_IN,
   input wire logic [`FEAT_CHARS*`CHAR_W-1:0] FEAT_CODE_IN,
   output logic ALARM_A_OUT,
   output logic ALARM_B_OUT,
   output logic MUTE_OUT,
   output logic BEEP_OUT,
   output logic UNDERVOLT_OUT,
   output logic [`VOLT_W-1:0] SUPPLY_DV_OUT,
   output logic [`VOLT_W-1:0] THRESH_DV_OUT,
   output logic LAMP_TEST_OUT,
   output logic SELF_TEST_OUT,
   output logic ADMIN_OUT,
   output logic [2:0] BOOT_CODE_OUT,
   output logic REBOOT_OUT,
   output logic IMAGE_OUT,
   output var alarm_maint_pkg::install_e INSTALL_STATE_OUT,
   output logic FEAT_PERM_OUT,
   output logic TRIAL_ACTIVE_OUT,
   output logic [`FEAT_CHARS*`CHAR_W-1:0] FEAT_CODE_OUT,
   output logic [`HOURS_W-1:0] TRIAL_HOURS_OUT,
   output logic TRIAL7_OUT,
   output logic TRIAL24_OUT
);
   // ==========================================================
   // fault sources and routing
   logic [`NUM_FULL_SRC-1:0] src;
   logic [`NUM_FULL_SRC-1:0] hit_a;
   logic [`NUM_FULL_SRC-1:0] hit_b;
   logic [`NUM_FULL_SRC-1:0] hit_m;
   logic test_active;
   logic next_a;
   logic next_b;
   logic next_beep;
   logic undervolt;
   logic trial7;
   logic trial24;
   assign test_active = (TEST_MODE_IN != alarm_maint_pkg::TEST_OFF);
   assign src[`SRC_REF] = FAULT_IN.ref_osc;
   assign src[`SRC_IPCTL] = FAULT_IN.ipctl;
   assign src[`SRC_OVEN] = FAULT_IN.oven;
   assign src[`SRC_MONITOR] = FAULT_IN.monitor;
   assign src[`SRC_SUPPLY] = undervolt;
   assign src[`SRC_TRIAL7] = trial7;
   assign src[`SRC_TRIAL24] = trial24;
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_FULL_SRC; gi++)
      begin : g_route
         assign hit_a[gi] = src[gi] & ROUTE_CFG_IN.full[gi][`SEL_BIT_A];
         assign hit_b[gi] = src[gi] & ROUTE_CFG_IN.full[gi][`SEL_BIT_B];
         assign hit_m[gi] = src[gi] & ROUTE_CFG_IN.full[gi][`SEL_BIT_MUTE];
      end
   endgenerate
   assign next_a = (|hit_a) | (test_active & ROUTE_CFG_IN.test_sel[`SEL_BIT_A])
                   | (FAULT_IN.hw & ROUTE_CFG_IN.hw_sel[`SEL_BIT_A]);
   assign next_b = (|hit_b) | (test_active & ROUTE_CFG_IN.test_sel[`SEL_BIT_B])
                   | (FAULT_IN.hw & ROUTE_CFG_IN.hw_sel[`SEL_BIT_B]);
   assign next_beep = (next_a & ROUTE_CFG_IN.beep_sel[`SEL_BIT_A])
                      | (next_b & ROUTE_CFG_IN.beep_sel[`SEL_BIT_B]);
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         ALARM_A_OUT <= 1'b0;
         ALARM_B_OUT <= 1'b0;
         MUTE_OUT <= 1'b0;
         BEEP_OUT <= 1'b0;
      end
      else
      begin
         ALARM_A_OUT <= next_a;
         ALARM_B_OUT <= next_b;
         // mute is or of mute routes
         MUTE_OUT <= |hit_m;
         BEEP_OUT <= next_beep;
      end
   end
   // ==========================================================
   // supply monitor
   // out-of-range threshold writes are dropped, old value kept
   assign undervolt = (SUPPLY_DV_OUT < THRESH_DV_OUT);
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         SUPPLY_DV_OUT <= '0;
         THRESH_DV_OUT <= `VOLT_RST_DV;
         UNDERVOLT_OUT <= 1'b0;
      end
      else
      begin
         SUPPLY_DV_OUT <= SUPPLY_DV_IN;
         if (THRESH_WR_IN && THRESH_DV_IN >= `VOLT_MIN_DV && THRESH_DV_IN <= `VOLT_MAX_DV)
         begin
            THRESH_DV_OUT <= THRESH_DV_IN;
         end
         UNDERVOLT_OUT <= undervolt;
      end
   end
   // ==========================================================
   // test mode, admin, image and installer
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         LAMP_TEST_OUT <= 1'b0;
         SELF_TEST_OUT <= 1'b0;
         ADMIN_OUT <= 1'b0;
         IMAGE_OUT <= 1'b0;
         INSTALL_STATE_OUT <= alarm_maint_pkg::INST_IDLE;
      end
      else
      begin
         LAMP_TEST_OUT <= TEST_MODE_IN[0];
         SELF_TEST_OUT <= TEST_MODE_IN[1];
         ADMIN_OUT <= ADMIN_IN;
         // selection in admin, else running image
         if (!ADMIN_OUT)
         begin
            IMAGE_OUT <= RUNNING_IMAGE_IN;
         end
         else if (IMAGE_WR_IN)
         begin
            IMAGE_OUT <= IMAGE_SEL_IN;
         end
         INSTALL_STATE_OUT <= alarm_maint_pkg::install_e'(INSTALL_STATE_IN);
      end
   end
   // ==========================================================
   // delayed reboot
   alarm_maint_pkg::boot_state_e boot_state;
   logic [`DLY_W-1:0] boot_cnt;
   logic boot_take;
   function automatic logic [`DLY_W-1:0] boot_delay(input logic [2:0] code);
      logic [5:0] secs;
      secs = `BOOT_S1;
      case (alarm_maint_pkg::boot_code_e'(code))
         alarm_maint_pkg::BOOT_2S: secs = `BOOT_S2;
         alarm_maint_pkg::BOOT_5S: secs = `BOOT_S5;
         alarm_maint_pkg::BOOT_10S: secs = `BOOT_S10;
         alarm_maint_pkg::BOOT_20S: secs = `BOOT_S20;
         alarm_maint_pkg::BOOT_50S: secs = `BOOT_S50;
         default: secs = `BOOT_S1;
      endcase
      return `DLY_W'(secs * SEC_CYCLES - 1);
   endfunction
   // write taken only with admin on
   assign boot_take = BOOT_WR_IN & ADMIN_OUT;
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         boot_state <= alarm_maint_pkg::BST_IDLE;
         boot_cnt <= '0;
         BOOT_CODE_OUT <= alarm_maint_pkg::BOOT_NORMAL;
         REBOOT_OUT <= 1'b0;
      end
      else
      begin
         REBOOT_OUT <= 1'b0;
         // code picks immediate or timed reboot
         if (boot_take)
         begin
            BOOT_CODE_OUT <= BOOT_CODE_IN;
            boot_cnt <= boot_delay(BOOT_CODE_IN);
            case (alarm_maint_pkg::boot_code_e'(BOOT_CODE_IN))
               alarm_maint_pkg::BOOT_NORMAL: boot_state <= alarm_maint_pkg::BST_IDLE;
               alarm_maint_pkg::BOOT_NOW: boot_state <= alarm_maint_pkg::BST_FIRE;
               default: boot_state <= alarm_maint_pkg::BST_WAIT;
            endcase
         end
         else
         begin
            case (boot_state)
               alarm_maint_pkg::BST_WAIT:
               begin
                  if (boot_cnt == '0)
                     boot_state <= alarm_maint_pkg::BST_FIRE;
                  else
                     boot_cnt <= boot_cnt - 1'b1;
               end
               alarm_maint_pkg::BST_FIRE:
               begin
                  // one-cycle pulse, then back to normal
                  REBOOT_OUT <= 1'b1;
                  BOOT_CODE_OUT <= alarm_maint_pkg::BOOT_NORMAL;
                  boot_state <= alarm_maint_pkg::BST_IDLE;
               end
               default: boot_state <= alarm_maint_pkg::BST_IDLE;
            endcase
         end
      end
   end
   // ==========================================================
   // feature codes and trial clock
   logic [`DLY_W-1:0] sec_cnt;
   logic [`DLY_W-1:0] hsec_cnt;
   logic hour_tick;

   // free-running; the first trial hour may be short by up to a whole hour
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         sec_cnt <= '0;
         hsec_cnt <= '0;
         hour_tick <= 1'b0;
      end
      else
      begin
         hour_tick <= 1'b0;
         if (sec_cnt == `DLY_W'(SEC_CYCLES - 1))
         begin
            sec_cnt <= '0;
            if (hsec_cnt == `DLY_W'(HOUR_SECS - 1))
            begin
               hsec_cnt <= '0;
               hour_tick <= 1'b1;
            end
            else
               hsec_cnt <= hsec_cnt + 1'b1;
         end
         else
            sec_cnt <= sec_cnt + 1'b1;
      end
   end
   assign trial7 = TRIAL_ACTIVE_OUT & (TRIAL_HOURS_OUT < `TRIAL7_HOURS);
   assign trial24 = TRIAL_ACTIVE_OUT & (TRIAL_HOURS_OUT < `TRIAL24_HOURS);
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         FEAT_PERM_OUT <= 1'b0;
         TRIAL_ACTIVE_OUT <= 1'b0;
         FEAT_CODE_OUT <= '0;
         TRIAL_HOURS_OUT <= '0;
         TRIAL7_OUT <= 1'b0;
         TRIAL24_OUT <= 1'b0;
      end
      else
      begin
         TRIAL7_OUT <= trial7;
         TRIAL24_OUT <= trial24;
         if (FEAT_WR_IN)
         begin
            FEAT_CODE_OUT <= FEAT_CODE_IN;
            if (FEAT_TRIAL_IN)
            begin
               TRIAL_ACTIVE_OUT <= 1'b1;
               TRIAL_HOURS_OUT <= TRIAL_HOURS;
            end
            else
            begin
               FEAT_PERM_OUT <= 1'b1;
            end
         end
         // hourly countdown, ends trial at zero
         else if (hour_tick && TRIAL_ACTIVE_OUT)
         begin
            if (TRIAL_HOURS_OUT <= `HOURS_W'(1))
            begin
               TRIAL_HOURS_OUT <= '0;
               TRIAL_ACTIVE_OUT <= 1'b0;
            end
            else
            begin
               TRIAL_HOURS_OUT <= TRIAL_HOURS_OUT - 1'b1;
            end
         end
      end
   end
   // ==========================================================
   // assertions
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!ARST_N_IN);
   route_ref_a_a: assert property (FAULT_IN.ref_osc && ROUTE_CFG_IN.full[`SRC_REF] == 3'h5
      |=> ALARM_A_OUT && MUTE_OUT) else $error("reference fault code 5 did not give A and mute");
   route_ipctl_a: assert property (FAULT_IN.ipctl && ROUTE_CFG_IN.full[`SRC_IPCTL] == 3'h2
      |=> ALARM_B_OUT) else $error("ip port fault code 2 did not give B");
   mute_source_a: assert property (MUTE_OUT |-> $past(|hit_m))
      else $error("mute without a routed source");
   no_mute_red_a: assert property (src == '0 |=> !MUTE_OUT)
      else $error("mute from reduced selector source");
   beep_map_a: assert property (ROUTE_CFG_IN.beep_sel == 2'h0 |=> !BEEP_OUT)
      else $error("beep while beeper off");
   thresh_range_a: assert property (THRESH_DV_OUT >= `VOLT_MIN_DV
      && THRESH_DV_OUT <= `VOLT_MAX_DV) else $error("threshold out of range");
   boot_lock_a: assert property (BOOT_WR_IN && !ADMIN_OUT && !REBOOT_OUT
      && boot_state == alarm_maint_pkg::BST_IDLE |=> $stable(BOOT_CODE_OUT))
      else $error("boot code changed without admin");
   boot_now_a: assert property (boot_take && BOOT_CODE_IN == 3'h1 |=> ##1 REBOOT_OUT)
      else $error("immediate reboot not issued");
   trial_warn_a: assert property (TRIAL24_OUT |-> TRIAL7_OUT)
      else $error("day warning without week warning");
   undervolt_a: assert property (SUPPLY_DV_OUT < THRESH_DV_OUT |=> UNDERVOLT_OUT)
      else $error("undervoltage not flagged");
   reboot_c: cover property (REBOOT_OUT);
   mute_beep_c: cover property (MUTE_OUT && BEEP_OUT);
   trial_end_c: cover property (TRIAL_ACTIVE_OUT ##1 !TRIAL_ACTIVE_OUT);
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the alarm routing and maintenance block
`timescale 1ns/100ps
`default_nettype none
module testbench;
// ======================================
// signals and notes
localparam int ALM = 0, THR = 1, UVK = 2, BOOT = 3, IMG = 4, INS = 5;
localparam int FEAT = 6, HRS = 7, TST = 8, ADM = 9, CODE = 10;
typedef struct {int due; int kind; logic [159:0] exp;} note_s;
note_s q[$];
note_s cur;
int cyc = 0, error_cnt = 0, tests_run = 0;
int secs[8] = '{0, 0, 1, 2, 5, 10, 20, 50};
logic clk = 0, arst_n = 0;
alarm_maint_pkg::route_cfg_s cfg = '0;
alarm_maint_pkg::fault_s fault = '0;
alarm_maint_pkg::install_e inst_o;
logic [8:0] supply = 9'h0f0, thr = 9'h050, supply_o, thr_o;
logic thr_wr = 0, admin = 0, boot_wr = 0, img_wr = 0, img_sel = 0, run_img = 0;
logic feat_wr = 0, feat_trial = 0;
logic [1:0] test_mode = 0, inst = 0;
logic [2:0] boot_code = 0, boot_o;
logic [159:0] feat_code = '0, code_o;
logic a_o, b_o, mute_o, beep_o, uv_o, lamp_o, self_o, adm_o, reboot_o, img_o;
logic perm_o, act_o, t7_o, t24_o;
logic [15:0] hrs_o;
always #50 clk = ~clk;
// short counts: one second is 10 cycles, one hour 4 seconds
alarm_maint #(.SEC_CYCLES(10), .HOUR_SECS(4), .TRIAL_HOURS(16'h001e)) u_alarm_maint (
   .MCLK_IN(clk), .ARST_N_IN(arst_n), .ROUTE_CFG_IN(cfg), .FAULT_IN(fault),
   .SUPPLY_DV_IN(supply), .THRESH_WR_IN(thr_wr), .THRESH_DV_IN(thr),
   .TEST_MODE_IN(test_mode), .ADMIN_IN(admin), .BOOT_WR_IN(boot_wr),
   .BOOT_CODE_IN(boot_code), .IMAGE_WR_IN(img_wr), .IMAGE_SEL_IN(img_sel),
   .RUNNING_IMAGE_IN(run_img), .INSTALL_STATE_IN(inst), .FEAT_WR_IN(feat_wr),
   .FEAT_TRIAL_IN(feat_trial), .FEAT_CODE_IN(feat_code), .ALARM_A_OUT(a_o),
   .ALARM_B_OUT(b_o), .MUTE_OUT(mute_o), .BEEP_OUT(beep_o), .UNDERVOLT_OUT(uv_o),
   .SUPPLY_DV_OUT(supply_o), .THRESH_DV_OUT(thr_o), .LAMP_TEST_OUT(lamp_o),
   .SELF_TEST_OUT(self_o), .ADMIN_OUT(adm_o), .BOOT_CODE_OUT(boot_o),
   .REBOOT_OUT(reboot_o), .IMAGE_OUT(img_o), .INSTALL_STATE_OUT(inst_o),
   .FEAT_PERM_OUT(perm_o), .TRIAL_ACTIVE_OUT(act_o), .FEAT_CODE_OUT(code_o),
   .TRIAL_HOURS_OUT(hrs_o), .TRIAL7_OUT(t7_o), .TRIAL24_OUT(t24_o));
// ======================================
// helpers
function automatic logic [159:0] obs(int k);
   case (k)
      ALM: return 160'({beep_o, mute_o, b_o, a_o});
      THR: return 160'(thr_o);
      UVK: return 160'({supply_o, uv_o});
      BOOT: return 160'({reboot_o, boot_o});
      IMG: return 160'(img_o);
      FEAT: return 160'({t24_o, t7_o, act_o, perm_o});
      HRS: return 160'(hrs_o);
      TST: return 160'({self_o, lamp_o});
      ADM: return 160'(adm_o);
      CODE: return code_o;
      default: return 160'(inst_o);
   endcase
endfunction
// expected {beep, mute, b, a} from the four fault inputs, test mode and hw fault
function automatic logic [3:0] route(alarm_maint_pkg::route_cfg_s c,
   alarm_maint_pkg::fault_s f, logic [1:0] tm);
   logic [6:0] act;
   logic [2:0] m;
   act = {2'b00, 1'b0, f.monitor, f.oven, f.ipctl, f.ref_osc};
   m = '0;
   for (int i = 0; i < 7; i++)
      if (act[i])
         m = m | c.full[i];
   if (tm != 2'h0)
      m = m | {1'b0, c.test_sel};
   if (f.hw)
      m = m | {1'b0, c.hw_sel};
   return {(c.beep_sel[0] & m[0]) | (c.beep_sel[1] & m[1]), m};
endfunction
// kept sorted by due cycle so the monitor can always pop the front
task automatic note(int k, logic [159:0] e, int lat);
   int i;
   note_s n;
   n = '{cyc + 1 + lat, k, e};
   i = q.size();
   while (i > 0 && q[i - 1].due > n.due)
      i--;
   q.insert(i, n);
endtask
task automatic tick(int n);
   repeat (n) @(posedge clk);
endtask
task automatic compare(int k, logic [159:0] e);
   tests_run++;
   if (obs(k) !== e)
   begin
      error_cnt++;
      $display("BAD %0t kind %0d got %0h exp %0h", $time, k, obs(k), e);
   end
endtask
task automatic wait_for(int k, logic [159:0] v, int lim);
   int n;
   n = 0;
   // look where the outputs have settled, not in the launching step
   do
   begin
      @(negedge clk);
      n++;
   end
   while (obs(k) !== v && n < lim);
   if (obs(k) !== v)
   begin
      error_cnt++;
      $display("BAD %0t wait ran out", $time);
   end
   // back on a rising edge so later notes line up with cyc
   @(posedge clk);
endtask
task automatic boot_go(logic [2:0] c, bit fire);
   @(posedge clk);
   boot_wr <= 1'b1;
   boot_code <= c;
   if (fire)
   begin
      note(BOOT, {1'b0, c}, 1);
      note(BOOT, {1'b0, c}, secs[c] * 10 + 1);
      note(BOOT, 4'h8, secs[c] * 10 + 2);
      note(BOOT, 4'h0, secs[c] * 10 + 3);
   end
   @(posedge clk);
   boot_wr <= 1'b0;
endtask
task automatic set_thr(logic [8:0] v);
   @(posedge clk);
   thr_wr <= 1'b1;
   thr <= v;
   @(posedge clk);
   thr_wr <= 1'b0;
endtask
task automatic stop_test;
   $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
   if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
   else
      $display("Testbench failed");
   $finish;
endtask
// ======================================
// monitor: results are taken in the middle of each cycle
always @(negedge clk)
begin
   cyc = cyc + 1;
   while (q.size() > 0 && q[0].due <= cyc)
   begin
      cur = q.pop_front();
      compare(cur.kind, cur.exp);
   end
end
// ======================================
// stimulus
initial
begin
   alarm_maint_pkg::route_cfg_s c;
   alarm_maint_pkg::fault_s f;
   logic [1:0] tm;
   logic [8:0] tv[5];
   logic [8:0] t;
   logic [159:0] v;
   tv = '{9'h04b, 9'h04c, 9'h155, 9'h154, 9'h064};
   t = 9'h050;
   tick(3);
   arst_n <= 1'b1;
   void'($urandom(50));
   tick(1);
   note(THR, 9'h050, 0);
   note(BOOT, 0, 0);
   note(FEAT, 0, 0);
   tick(2);
   $display("done reset");
   for (int i = 0; i < 64; i++)
   begin
      @(posedge clk);
      c = alarm_maint_pkg::route_cfg_s'($urandom);
      for (int s = 0; s < 4; s++)
         c.full[s] = 3'(i + s);
      f = alarm_maint_pkg::fault_s'($urandom);
      tm = 2'($urandom);
      cfg <= c;
      fault <= f;
      test_mode <= tm;
      note(ALM, route(c, f, tm), 1);
      note(TST, tm, 1);
   end
   @(posedge clk);
   c = '0;
   c.full[4] = 3'h7;
   cfg <= c;
   fault <= '0;
   test_mode <= 2'h0;
   $display("done routing");
   // out-of-range thresholds must leave the old value standing
   for (int j = 0; j < 5; j++)
   begin
      set_thr(tv[j]);
      if (j % 2 == 1 || j == 4)
         t = tv[j];
      note(THR, t, 0);
      @(posedge clk);
      supply <= t - 9'h001;
      note(UVK, {t - 9'h001, 1'b1}, 3);
      note(ALM, 4'h7, 3);
      tick(4);
      supply <= t;
      note(UVK, {t, 1'b0}, 3);
      note(ALM, 4'h0, 3);
      tick(4);
   end
   supply <= 9'h0f0;
   $display("done threshold");
   boot_go(3'h1, 0);
   note(BOOT, 0, 0);
   note(BOOT, 0, 2);
   tick(3);
   admin <= 1'b1;
   note(ADM, 1, 1);
   tick(2);
   for (int k = 1; k < 8; k++)
   begin
      boot_go(3'(k), 1);
      tick(secs[k] * 10 + 4);
   end
   // a rewrite restarts the delay from the new write
   boot_go(3'h2, 0);
   tick(3);
   boot_go(3'h3, 1);
   note(BOOT, 4'h3, 6);
   tick(25);
   boot_go(3'h2, 0);
   tick(2);
   boot_go(3'h0, 0);
   note(BOOT, 0, 0);
   note(BOOT, 0, 7);
   tick(9);
   admin <= 1'b0;
   $display("done boot");
   @(posedge clk);
   run_img <= 1'b1;
   img_wr <= 1'b1;
   note(IMG, 1, 1);
   note(IMG, 1, 2);
   @(posedge clk);
   img_wr <= 1'b0;
   admin <= 1'b1;
   tick(2);
   img_wr <= 1'b1;
   note(IMG, 0, 1);
   note(IMG, 0, 4);
   @(posedge clk);
   img_wr <= 1'b0;
   tick(4);
   admin <= 1'b0;
   note(IMG, 1, 3);
   tick(4);
   $display("done image");
   for (int i = 0; i < 4; i++)
   begin
      @(posedge clk);
      inst <= 2'(i);
      note(INS, i, 1);
   end
   tick(2);
   $display("done installer");
   c = '0;
   c.full[5] = 3'h1;
   c.full[6] = 3'h2;
   cfg <= c;
   @(posedge clk);
   v = {5{$urandom}};
   feat_wr <= 1'b1;
   feat_code <= v;
   note(CODE, v, 1);
   note(FEAT, 1, 1);
   @(posedge clk);
   feat_trial <= 1'b1;
   feat_code <= ~v;
   note(CODE, ~v, 1);
   note(HRS, 30, 1);
   note(FEAT, 4'h7, 2);
   note(ALM, 4'h1, 3);
   @(posedge clk);
   feat_wr <= 1'b0;
   wait_for(HRS, 23, 400);
   note(FEAT, 4'hf, 0);
   note(ALM, 4'h3, 2);
   wait_for(FEAT, 1, 1500);
   note(HRS, 0, 0);
   note(ALM, 0, 2);
   tick(4);
   $display("done feature");
   stop_test();
end
// run needs about 2300 cycles
initial
begin
   tick(20000);
   error_cnt++;
   $display("BAD %0t watchdog ran out", $time);
   stop_test();
end
endmodule
`default_nettype wire
